// ---- shared/wake_pkg.sv ----
package wake_pkg;

   // Register map, printed word addresses
   localparam logic [15:0] ADDR_CONFIG = 16'h04A0;
   localparam logic [15:0] ADDR_STATUS = 16'h04A1;
   localparam logic [15:0] ADDR_DA1    = 16'h04A2;
   localparam logic [15:0] ADDR_DA3    = 16'h04A4;
   localparam logic [15:0] ADDR_PW1    = 16'h04A5;
   localparam logic [15:0] ADDR_PW3    = 16'h04A7;

   // Configuration fields
   localparam int CFG_ORDER_HI = 15;
   localparam int CFG_ORDER_LO = 14;
   localparam int CFG_SFD_SEL  = 13;
   localparam int CFG_CRC_GATE = 12;
   localparam int CFG_LVL_CLR  = 11;
   localparam int CFG_PULSE_HI = 10;
   localparam int CFG_PULSE_LO = 9;
   localparam int CFG_IND_SEL  = 8;
   localparam int CFG_ENABLE   = 7;
   localparam int CFG_PASS_EN  = 5;
   localparam int CFG_PAT_EN   = 1;
   localparam int CFG_MAGIC_EN = 0;
   localparam logic [15:0] CONFIG_RESET = 16'h1000;
   localparam logic [15:0] CONFIG_WMASK = 16'hF7FF;

   // Status fields
   localparam int STS_SRC     = 12;
   localparam int STS_SFD_ERR = 7;
   localparam int STS_BAD_CRC = 6;
   localparam int STS_HACK    = 5;
   localparam int STS_PAT     = 1;
   localparam int STS_MAGIC   = 0;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] ADDR_WORD_RESET = 16'h0000;

   // Frame constants
   localparam logic [7:0] SFD_ALT     = 8'h5D;
   localparam logic [7:0] SFD_STD     = 8'hD5;
   localparam logic [7:0] PREAMBLE    = 8'h55;
   localparam logic [7:0] SYNC_BYTE   = 8'hFF;
   localparam logic [2:0] SYNC_LEN    = 3'h6;
   localparam logic [2:0] LAST_POS    = 3'h5;
   localparam logic [6:0] ADDR_TOTAL  = 7'h60;
   localparam logic [6:0] PULSE_BASE  = 7'h08;

   typedef enum logic [1:0] {
      RX_IDLE     = 2'b00,
      RX_PREAMBLE = 2'b01,
      RX_DATA     = 2'b10,
      RX_SKIP     = 2'b11
   } rx_state_e;

   typedef enum logic [1:0] {
      MG_SYNC = 2'b00,
      MG_ADDR = 2'b01,
      MG_PASS = 2'b10,
      MG_DONE = 2'b11
   } magic_state_e;

endpackage

// ---- rtl/wake_on_lan_detector.sv ----
// Functional notes
// - Ordering field 00 normal, 01 bit reverse, 10 nibble swap, 11 per-nibble reverse.
// - Search delimiter 0x5D when select bit is one, else 0xD5.
// - CRC gating set (reset value) suppresses magic and pattern on bad CRC.
// - Gating clear: bad-CRC frame gives no status, interrupt or pin indication.
// - Self-clearing clear bit drops the level indication; reads back zero.
// - Indication select: one is level mode, zero (reset) is pulse mode.
// - Wake detection works only while the master enable bit is set.
// - Password enable requires a matching password in magic packets.
// - Pattern enable raises wake on a packet holding the pattern.
// - Magic enable raises wake on a valid magic packet.
// - Source bit routes wake (one) or polarity (zero) to interrupt bit 1.
// - Enabling wake detection sets the source bit to wake.
// - Latched read-cleared flag when a packet lacks the selected delimiter.
// - Latched read-cleared flag when a bad-CRC frame arrives.
// - Latched read-cleared intrusion flag on a wrong magic password.
// - Latched read-cleared flag on a valid pattern packet.
// - Latched read-cleared flag on a valid magic packet.
// - Magic address is six bytes in three two-byte registers.
// - Password is six bytes in three two-byte registers.
`timescale 1ns/1ps
`default_nettype none

module wake_on_lan_detector
   import wake_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_end,
   input  wire logic        rx_crc_bad,
   input  wire logic        pattern_hit,
   input  wire logic        polarity_irq,
   output logic             wake_out,
   output logic             irq_bit1
);

   logic [15:0]  cfg_r;
   logic [15:0]  stat_r;
   logic [15:0]  stat_nxt;
   logic         src_nxt;
   logic [15:0]  rdata_r;
   logic [15:0]  rd_mux;
   rx_state_e    rx_r;
   rx_state_e    rx_nxt;
   magic_state_e mg_r;
   logic [2:0]   ff_cnt_r;
   logic [2:0]   pos_r;
   logic [6:0]   addr_cnt_r;
   logic         pass_bad_r;
   logic         magic_hit_r;
   logic         hack_hit_r;
   logic         pat_hit_r;
   logic         wake_lvl_r;
   logic         wake_lvl_nxt;
   logic [6:0]   pulse_cnt_r;
   logic [6:0]   pulse_cnt_nxt;
   logic         wake_out_r;
   logic         irq_r;

   // Register decode
   wire cfg_wr  = reg_wr && (reg_addr == ADDR_CONFIG);
   wire stat_wr = reg_wr && (reg_addr == ADDR_STATUS);
   wire stat_rd = reg_rd && (reg_addr == ADDR_STATUS);
   wire da_hit  = (reg_addr >= ADDR_DA1) && (reg_addr <= ADDR_DA3);
   wire pw_hit  = (reg_addr >= ADDR_PW1) && (reg_addr <= ADDR_PW3);
   wire [15:0] da_off = reg_addr - ADDR_DA1;
   wire [15:0] pw_off = reg_addr - ADDR_PW1;
   wire [1:0]  da_idx = da_off[1:0];
   wire [1:0]  pw_idx = pw_off[1:0];

   wire        en       = cfg_r[CFG_ENABLE];
   wire [1:0]  order    = cfg_r[CFG_ORDER_HI:CFG_ORDER_LO];
   wire        ind_lvl  = cfg_r[CFG_IND_SEL];
   wire [1:0]  pulse_sel = cfg_r[CFG_PULSE_HI:CFG_PULSE_LO];
   wire        crc_gate = cfg_r[CFG_CRC_GATE];

   // Address and password words; bytes indexed by wire order
   logic [15:0] da_word [0:2];
   logic [15:0] pw_word [0:2];
   logic [7:0]  dest_byte [0:5];
   logic [7:0]  pass_byte [0:5];

   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_words
         logic [15:0] da_r;
         logic [15:0] pw_r;
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               da_r <= ADDR_WORD_RESET;
               pw_r <= ADDR_WORD_RESET;
            end else begin
               if (reg_wr && da_hit && (da_idx == 2'(k))) begin
                  da_r <= reg_wdata;
               end
               if (reg_wr && pw_hit && (pw_idx == 2'(k))) begin
                  pw_r <= reg_wdata;
               end
            end
         end
         assign da_word[k] = da_r;
         assign pw_word[k] = pw_r;
         // First register holds the last two address bytes
         assign dest_byte[4 - 2 * k] = da_r[15:8];
         assign dest_byte[5 - 2 * k] = da_r[7:0];
         assign pass_byte[2 * k + 1] = pw_r[15:8];
         assign pass_byte[2 * k]     = pw_r[7:0];
      end
   endgenerate

   // Byte ordering applied before any compare
   wire [7:0] rev_byte  = {rx_data[0], rx_data[1], rx_data[2], rx_data[3],
                           rx_data[4], rx_data[5], rx_data[6], rx_data[7]};
   wire [7:0] swap_byte = {rx_data[3:0], rx_data[7:4]};
   wire [7:0] nrev_byte = {rev_byte[3:0], rev_byte[7:4]};
   wire [7:0] ord_byte  = (order == 2'b00) ? rx_data   :
                          (order == 2'b01) ? rev_byte  :
                          (order == 2'b10) ? swap_byte : nrev_byte;

   wire [7:0] sfd_byte = cfg_r[CFG_SFD_SEL] ? SFD_ALT : SFD_STD;

   // Delimiter search
   wire hunt      = (rx_r == RX_IDLE) || (rx_r == RX_PREAMBLE);
   wire sfd_found = hunt && rx_valid && (ord_byte == sfd_byte);
   wire sfd_bad   = (hunt && rx_valid && (ord_byte != sfd_byte)
                     && (ord_byte != PREAMBLE))
                    || (rx_end && (rx_r == RX_PREAMBLE));
   wire frame_end = rx_end && (rx_r == RX_DATA);

   always_comb begin
      rx_nxt = rx_r;
      case (rx_r)
         RX_IDLE, RX_PREAMBLE: begin
            if (rx_end) begin
               rx_nxt = RX_IDLE;
            end else if (sfd_found) begin
               rx_nxt = RX_DATA;
            end else if (sfd_bad) begin
               rx_nxt = RX_SKIP;
            end else if (rx_valid) begin
               rx_nxt = RX_PREAMBLE;
            end
         end
         RX_DATA, RX_SKIP: begin
            if (rx_end) begin
               rx_nxt = RX_IDLE;
            end
         end
         default: rx_nxt = RX_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_r <= RX_IDLE;
      end else begin
         rx_r <= rx_nxt;
      end
   end

   // Magic packet matcher; runs over the whole frame body
   wire data_byte = rx_valid && (rx_r == RX_DATA);
   wire addr_ok   = (ord_byte == dest_byte[pos_r]);
   wire [2:0] pos_inc = (pos_r == LAST_POS) ? 3'h0 : pos_r + 3'h1;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mg_r        <= MG_SYNC;
         ff_cnt_r    <= 3'h0;
         pos_r       <= 3'h0;
         addr_cnt_r  <= 7'h00;
         pass_bad_r  <= 1'b0;
         magic_hit_r <= 1'b0;
         hack_hit_r  <= 1'b0;
         pat_hit_r   <= 1'b0;
      end else if (rx_r != RX_DATA) begin
         mg_r        <= MG_SYNC;
         ff_cnt_r    <= 3'h0;
         pos_r       <= 3'h0;
         addr_cnt_r  <= 7'h00;
         pass_bad_r  <= 1'b0;
         magic_hit_r <= 1'b0;
         hack_hit_r  <= 1'b0;
         pat_hit_r   <= 1'b0;
      end else begin
         if (pattern_hit) begin
            pat_hit_r <= 1'b1;
         end
         if (data_byte) begin
            case (mg_r)
               MG_SYNC: begin
                  // Extra 0xFF bytes are tolerated before the address
                  if (ord_byte == SYNC_BYTE && ff_cnt_r != SYNC_LEN) begin
                     ff_cnt_r <= ff_cnt_r + 3'h1;
                  end else if (ff_cnt_r == SYNC_LEN && addr_ok) begin
                     mg_r       <= MG_ADDR;
                     pos_r      <= pos_inc;
                     addr_cnt_r <= 7'h01;
                  end else if (ord_byte != SYNC_BYTE) begin
                     ff_cnt_r <= 3'h0;
                  end
               end
               MG_ADDR: begin
                  if (addr_ok) begin
                     pos_r      <= pos_inc;
                     addr_cnt_r <= addr_cnt_r + 7'h01;
                     if (addr_cnt_r + 7'h01 == ADDR_TOTAL) begin
                        pos_r <= 3'h0;
                        if (cfg_r[CFG_PASS_EN]) begin
                           mg_r <= MG_PASS;
                        end else begin
                           mg_r        <= MG_DONE;
                           magic_hit_r <= 1'b1;
                        end
                     end
                  end else begin
                     mg_r     <= MG_SYNC;
                     pos_r    <= 3'h0;
                     ff_cnt_r <= (ord_byte == SYNC_BYTE) ? 3'h1 : 3'h0;
                  end
               end
               MG_PASS: begin
                  pos_r <= pos_inc;
                  if (pos_r == LAST_POS) begin
                     mg_r <= MG_DONE;
                     if (pass_bad_r || ord_byte != pass_byte[pos_r]) begin
                        hack_hit_r <= 1'b1;
                     end else begin
                        magic_hit_r <= 1'b1;
                     end
                  end else if (ord_byte != pass_byte[pos_r]) begin
                     pass_bad_r <= 1'b1;
                  end
               end
               MG_DONE: mg_r <= MG_DONE;
               default: mg_r <= MG_SYNC;
            endcase
         end
      end
   end

   // Delimiter-error and frame-end events; bad CRC never indicates a wake in either mode
   wire crc_ok  = !rx_crc_bad;
   wire ev_sfd  = en && sfd_bad;
   wire ev_crc  = en && frame_end && rx_crc_bad && crc_gate;
   wire ev_hack = en && frame_end && crc_ok && hack_hit_r;
   wire ev_mag  = en && frame_end && crc_ok && magic_hit_r
                  && cfg_r[CFG_MAGIC_EN];
   wire ev_pat  = en && frame_end && crc_ok
                  && (pat_hit_r || pattern_hit)
                  && cfg_r[CFG_PAT_EN];
   wire wake_ev = ev_mag || ev_pat;

   // Status: set wins over read clear
   always_comb begin
      stat_nxt = stat_r;
      if (stat_rd) begin
         stat_nxt[STS_SFD_ERR] = 1'b0;
         stat_nxt[STS_BAD_CRC] = 1'b0;
         stat_nxt[STS_HACK]    = 1'b0;
         stat_nxt[STS_PAT]     = 1'b0;
         stat_nxt[STS_MAGIC]   = 1'b0;
      end
      if (ev_sfd) begin
         stat_nxt[STS_SFD_ERR] = 1'b1;
      end
      if (ev_crc) begin
         stat_nxt[STS_BAD_CRC] = 1'b1;
      end
      if (ev_hack) begin
         stat_nxt[STS_HACK] = 1'b1;
      end
      if (ev_pat) begin
         stat_nxt[STS_PAT] = 1'b1;
      end
      if (ev_mag) begin
         stat_nxt[STS_MAGIC] = 1'b1;
      end
      stat_nxt[STS_SRC] = src_nxt;
   end

   assign src_nxt = (cfg_wr && reg_wdata[CFG_ENABLE]) ? 1'b1 :
                    stat_wr ? reg_wdata[STS_SRC] : stat_r[STS_SRC];

   // Wake indication
   wire [6:0] pulse_len = PULSE_BASE << pulse_sel;
   wire lvl_clear = cfg_wr && reg_wdata[CFG_LVL_CLR] && ind_lvl;

   assign wake_lvl_nxt = (wake_ev && ind_lvl) ? 1'b1 :
                         lvl_clear ? 1'b0 : wake_lvl_r;
   assign pulse_cnt_nxt = (wake_ev && !ind_lvl) ? pulse_len :
                          (pulse_cnt_r != 7'h00) ? pulse_cnt_r - 7'h01
                                                 : 7'h00;

   // Read mux; the clear bit always reads zero
   assign rd_mux = (reg_addr == ADDR_CONFIG) ? (cfg_r & CONFIG_WMASK) :
                   (reg_addr == ADDR_STATUS) ? stat_r :
                   da_hit ? da_word[da_idx] :
                   pw_hit ? pw_word[pw_idx] : 16'h0000;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= CONFIG_RESET;
      end else if (cfg_wr) begin
         cfg_r <= reg_wdata & CONFIG_WMASK;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stat_r      <= STATUS_RESET;
         wake_lvl_r  <= 1'b0;
         pulse_cnt_r <= 7'h00;
         wake_out_r  <= 1'b0;
         irq_r       <= 1'b0;
         rdata_r     <= 16'h0000;
      end else begin
         stat_r      <= stat_nxt;
         wake_lvl_r  <= wake_lvl_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         wake_out_r  <= ind_lvl ? wake_lvl_nxt : (pulse_cnt_nxt != 7'h00);
         irq_r       <= stat_r[STS_SRC] ?
                        (stat_nxt[STS_MAGIC] || stat_nxt[STS_PAT]) :
                        polarity_irq;
         rdata_r     <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;
   assign wake_out  = wake_out_r;
   assign irq_bit1  = irq_r;

   // Checks
   logic [6:0] since_load_r;
   logic [6:0] last_len_r;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         since_load_r <= 7'h00;
         last_len_r   <= 7'h00;
      end else if (wake_ev && !ind_lvl) begin
         since_load_r <= 7'h00;
         last_len_r   <= pulse_len;
      end else if (since_load_r != 7'h7F) begin
         since_load_r <= since_load_r + 7'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_pulse_length: assert property (
      ($fell(wake_out_r) && !ind_lvl && $stable(ind_lvl))
      |-> since_load_r == last_len_r)
      else $error("wake pulse length wrong");

   a_order_nibble: assert property (
      (order == 2'b11 && rx_data == 8'h01) |-> ord_byte == 8'h08)
      else $error("per-nibble reversal wrong");

   a_sfd_enter: assert property (
      (sfd_found && !rx_end) |=> rx_r == RX_DATA)
      else $error("delimiter not accepted");

   a_crc_gate: assert property (
      (frame_end && rx_crc_bad)
      |=> !$rose(stat_r[STS_MAGIC]) && !$rose(stat_r[STS_PAT])
          && !$rose(wake_out_r))
      else $error("bad CRC frame indicated wake");

   a_crc_flag: assert property (
      (en && frame_end && rx_crc_bad && crc_gate) |=> stat_r[STS_BAD_CRC])
      else $error("bad CRC flag not set");

   a_crc_silent: assert property (
      (frame_end && rx_crc_bad && !crc_gate && !stat_r[STS_BAD_CRC])
      |=> !stat_r[STS_BAD_CRC])
      else $error("bad CRC flagged with gate off");

   a_level_clear: assert property (
      (lvl_clear && !wake_ev) |=> !wake_out_r ##1 !(cfg_r[CFG_LVL_CLR]))
      else $error("level not cleared");

   a_level_hold: assert property (
      (ind_lvl && wake_ev && !cfg_wr) |=> wake_out_r [*2])
      else $error("level indication not held");

   a_enable_off: assert property (
      (!en && !stat_wr && !cfg_wr) |=> $stable(stat_r) or $fell(stat_r[0])
         or $fell(stat_r[1]) or $fell(stat_r[5]) or $fell(stat_r[6])
         or $fell(stat_r[7]))
      else $error("flag set while disabled");

   a_src_auto: assert property (
      (cfg_wr && reg_wdata[CFG_ENABLE]) |=> stat_r[STS_SRC])
      else $error("source bit not set on enable");

   a_irq_route: assert property (
      !stat_r[STS_SRC] |=> irq_r == $past(polarity_irq))
      else $error("polarity interrupt not routed");

   a_magic_flag: assert property (
      ev_mag |=> stat_r[STS_MAGIC] && wake_out_r)
      else $error("magic flag or wake missing");

   a_pattern_flag: assert property (
      ev_pat |=> stat_r[STS_PAT])
      else $error("pattern flag missing");

   a_hack_flag: assert property (
      ev_hack |=> stat_r[STS_HACK] && !$rose(stat_r[STS_MAGIC]))
      else $error("intrusion flag missing");

   a_sfd_flag: assert property (
      ev_sfd |=> stat_r[STS_SFD_ERR])
      else $error("delimiter error flag missing");

   c_magic_wake: cover property (ev_mag ##1 wake_out_r);
   c_pattern_wake: cover property (ev_pat && !ind_lvl);
   c_hack_seen: cover property (ev_hack);
   c_level_clear: cover property (wake_out_r && ind_lvl ##1 lvl_clear);

endmodule

`default_nettype wire

// ---- dv/wake_sender.sv ----
`timescale 1ns/1ps
`default_nettype none

module wake_sender
   import wake_pkg::*;
(
   input  wire logic       clock,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_end,
   output logic            rx_crc_bad,
   output logic            pattern_hit
);
   initial begin
      rx_valid    = 1'b0;
      rx_data     = 8'hA5;
      rx_end      = 1'b0;
      rx_crc_bad  = 1'b0;
      pattern_hit = 1'b0;
   end

   // Each code is its own inverse, so pre-ordering cancels the receiver's
   function automatic logic [7:0] order(input logic [7:0] b,
                                        input logic [1:0] c);
      case (c)
         2'b01: order = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
         2'b10: order = {b[3:0], b[7:4]};
         2'b11: order = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
         default: order = b;
      endcase
   endfunction

   task automatic put(input logic [7:0] b, input logic [1:0] c);
      rx_valid <= 1'b1;
      rx_data  <= order(b, c);
      @(posedge clock);
   endtask

   task automatic send(input logic [7:0] sfd, input logic [1:0] c,
                       input logic [47:0] da, input logic pw_on,
                       input logic [47:0] pw, input logic bad,
                       input logic pat);
      int i;
      @(posedge clock);
      put(PREAMBLE, c);
      put(sfd, c);
      pattern_hit <= pat;
      for (i = 0; i < 6; i++) begin
         put(SYNC_BYTE, c);
      end
      pattern_hit <= 1'b0;
      for (i = 0; i < 96; i++) begin
         put(da[47 - 8 * (i % 6) -: 8], c);
      end
      for (i = 0; i < 6 && pw_on; i++) begin
         put(pw[8 * i +: 8], c);
      end
      // Released data shows the inverse, never a stale byte
      rx_valid   <= 1'b0;
      rx_data    <= ~rx_data;
      rx_end     <= 1'b1;
      rx_crc_bad <= bad;
      @(posedge clock);
      rx_end     <= 1'b0;
      rx_crc_bad <= ~bad;
   endtask
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import wake_pkg::*;
;
   logic        clock;
   logic        nrst;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        rx_end;
   logic        rx_crc_bad;
   logic        pattern_hit;
   logic        polarity_irq;
   logic        wake_out;
   logic        irq_bit1;
   logic [15:0] d;
   logic [15:0] n;
   logic [15:0] rises = 16'h0000;
   logic [15:0] run = 16'h0000;
   logic [15:0] last_len = 16'h0000;
   logic        wake_q = 1'b0;
   logic        irq_seen;
   logic [31:0] r1;
   logic [31:0] r2;
   logic [47:0] da;
   logic [47:0] pw;
   integer      seed;
   int          i;
   int          err_total = 0;
   int          num_checks = 0;

   wake_on_lan_detector dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_end(rx_end), .rx_crc_bad(rx_crc_bad), .pattern_hit(pattern_hit),
      .polarity_irq(polarity_irq), .wake_out(wake_out), .irq_bit1(irq_bit1));

   wake_sender tx (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_end(rx_end), .rx_crc_bad(rx_crc_bad), .pattern_hit(pattern_hit));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Pulse length is measured at the pins, not trusted from the note
   always @(posedge clock) begin
      wake_q <= wake_out;
      if (wake_out && !wake_q) rises <= rises + 16'h0001;
      if (wake_out) run <= run + 16'h0001;
      else begin
         if (run != 16'h0000) last_len <= run;
         run <= 16'h0000;
      end
   end

   function automatic logic [15:0] pulse_len(input logic [1:0] c);
      pulse_len = 16'h0008 << c;
   endfunction

   function automatic logic [15:0] st(input int b);
      st = 16'h1000 | (16'h0001 << b);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Latched flags, then gone on the second read
   task automatic flags(input logic [15:0] e);
      rd(ADDR_STATUS, d);
      check(d, e, "status flags");
      rd(ADDR_STATUS, d);
      check(d, e & 16'h1000, "status read clear");
   endtask

   task automatic frame(input logic [7:0] sfd, input logic [1:0] c,
                        input logic pw_on, input logic [47:0] p,
                        input logic bad, input logic pat);
      logic [15:0] r0;
      r0 = rises;
      tx.send(sfd, c, da, pw_on, p, bad, pat);
      repeat (2) @(posedge clock);
      #1 irq_seen = irq_bit1;
      repeat (70) @(posedge clock);
      n = rises - r0;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      conclude();
   end

   initial begin
      seed = 32'hD745ADCF;
      nrst = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      polarity_irq = 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      rd(ADDR_CONFIG, d);
      check(d, CONFIG_RESET, "config reset");
      rd(ADDR_STATUS, d);
      check(d, STATUS_RESET, "status reset");
      rd(16'h04BF, d);
      check(d, 16'h0000, "unmapped read");
      r1 = $random(seed);
      r2 = $random(seed);
      da = {r1[15:0], r2};
      r1 = $random(seed);
      r2 = $random(seed);
      pw = {r1[15:0], r2};
      for (i = 0; i < 3; i++) begin
         wr(ADDR_DA1 + 16'(i), da[16 * i +: 16]);
         wr(ADDR_PW1 + 16'(i), pw[16 * i +: 16]);
      end
      for (i = 0; i < 3; i++) begin
         rd(ADDR_DA1 + 16'(i), d);
         check(d, da[16 * i +: 16], "address word");
         rd(ADDR_PW1 + 16'(i), d);
         check(d, pw[16 * i +: 16], "password word");
      end
      for (i = 0; i < 4; i++) begin
         r1 = $random(seed);
         wr(ADDR_CONFIG, {i[1:0], r1[0], 2'b10, i[1:0], 1'b0, 8'h81});
         frame(r1[0] ? SFD_ALT : SFD_STD, i[1:0], 1'b0, pw, 1'b0, 1'b0);
         check(16'(irq_seen), 16'h0001, "wake irq");
         check(n, 16'h0001, "one wake");
         check(last_len, pulse_len(i[1:0]), "pulse length");
         flags(st(STS_MAGIC));
      end
      wr(ADDR_CONFIG, 16'h1081);
      frame(SFD_ALT, 2'b00, 1'b0, pw, 1'b0, 1'b0);
      check(n, 16'h0000, "no wake sfd");
      flags(st(STS_SFD_ERR));
      frame(SFD_STD, 2'b00, 1'b0, pw, 1'b1, 1'b1);
      check(n, 16'h0000, "no wake crc");
      flags(st(STS_BAD_CRC));
      wr(ADDR_CONFIG, 16'h0083);
      frame(SFD_STD, 2'b00, 1'b0, pw, 1'b1, 1'b1);
      check(n + 16'(irq_seen), 16'h0000, "no wake gate off");
      flags(16'h1000);
      wr(ADDR_CONFIG, 16'h10A1);
      frame(SFD_STD, 2'b00, 1'b1, pw, 1'b0, 1'b0);
      check(n, 16'h0001, "wake password");
      flags(st(STS_MAGIC));
      frame(SFD_STD, 2'b00, 1'b1, pw ^ 48'h000100000000, 1'b0, 1'b0);
      check(n, 16'h0000, "no wake bad password");
      flags(st(STS_HACK));
      wr(ADDR_CONFIG, 16'h1082);
      frame(SFD_STD, 2'b00, 1'b0, pw, 1'b0, 1'b1);
      check(n, 16'h0001, "wake pattern");
      flags(st(STS_PAT));
      wr(ADDR_CONFIG, 16'h1003);
      frame(SFD_STD, 2'b00, 1'b0, pw, 1'b0, 1'b1);
      check(n, 16'h0000, "disabled");
      flags(16'h1000);
      wr(ADDR_CONFIG, 16'h1181);
      frame(SFD_STD, 2'b00, 1'b0, pw, 1'b0, 1'b0);
      check(16'(wake_out), 16'h0001, "level holds");
      wr(ADDR_CONFIG, 16'h1981);
      rd(ADDR_CONFIG, d);
      check(d, 16'h1181, "clear bit reads zero");
      check(16'(wake_out), 16'h0000, "level cleared");
      flags(st(STS_MAGIC));
      wr(ADDR_STATUS, 16'h0000);
      polarity_irq <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check(16'(irq_bit1), 16'h0001, "polarity routed");
      polarity_irq <= 1'b0;
      wr(ADDR_CONFIG, 16'h1081);
      rd(ADDR_STATUS, d);
      check(d, 16'h1000, "source auto set");
      conclude();
   end
endmodule

`default_nettype wire
